/* File: common/dcg_pkg.sv */
// constants and types for the dual codec gain and routing register bank
package dcg_pkg;

	// ==========================================================
	// register addresses (8-bit, equal to the register number)
	localparam logic [7:0] ADDR_C1_ADC_GAIN = 8'h03;
	localparam logic [7:0] ADDR_C1_DAC_GAIN = 8'h04;
	localparam logic [7:0] ADDR_C1_ROUTE = 8'h05;
	localparam logic [7:0] ADDR_C2_DIVIDER = 8'h06;
	localparam logic [7:0] ADDR_C2_CONFIG = 8'h07;
	localparam logic [7:0] ADDR_C2_ADC_GAIN = 8'h08;
	localparam logic [7:0] ADDR_C2_DAC_GAIN = 8'h09;
	localparam logic [7:0] ADDR_C2_ROUTE = 8'h0A;
	localparam logic [7:0] ADDR_GAIN_CTRL = 8'h15;

	// ==========================================================
	// field positions
	localparam int ADC_OVF_BIT = 7;
	localparam int ADC_GAIN_LSB = 1;
	localparam int LINE_OUT_BIT = 0;
	localparam int DAC_GAIN_LSB = 0;
	localparam int ROUTE_IN_LSB = 3;
	localparam int ROUTE_OUT_LSB = 0;
	localparam int CFG_DIV_LSB = 4;
	localparam int CFG_ALOOP_BIT = 3;
	localparam int CFG_DLOOP_BIT = 2;
	localparam int CFG_PDN_BIT = 1;
	localparam int CFG_SRST_BIT = 0;
	localparam int HOLD_BIT = 2;
	localparam int VERSION_LSB = 4;
	localparam int CTRL_RSVD_BIT = 3;

	// ==========================================================
	// reset values
	localparam logic [6:0] RST_C1_ADC = 7'h00;
	localparam logic [5:0] RST_C1_DAC = 6'h00;
	localparam logic [7:0] RST_C1_ROUTE = 8'h84;
	localparam logic [7:0] RST_C2_DIVIDER = 8'h50;
	localparam logic [7:0] RST_C2_CONFIG = 8'h50;
	localparam logic [6:0] RST_C2_ADC = 7'h01;
	localparam logic [5:0] RST_C2_DAC = 6'h00;
	localparam logic [5:0] RST_C2_ROUTE = 6'h04;
	localparam logic [7:0] RST_GAIN_CTRL = 8'h18;

	// ==========================================================
	// gain codes and identity
	localparam logic [5:0] GAIN_MUTE = 6'h30;
	localparam logic [5:0] GAIN_0DB = 6'h19;
	localparam logic [5:0] GAIN_ALT_0DB = 6'h00;
	localparam int NUM_GAINS = 4;
	// arbitrary version value, nonzero as required
	localparam logic [3:0] VERSION_ID = 4'h1;

	typedef logic [5:0] dcg_gain_t;

endpackage

/* File: verilog/dcg_gain_apply.sv */
// one applied gain stage: follows its register code unless held
module dcg_gain_apply (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic hold_in,
	input wire dcg_pkg::dcg_gain_t code_in,
	output dcg_pkg::dcg_gain_t gain_out,
	output logic mute_out
);
	import dcg_pkg::*;

	// ==========================================================
	// applied code
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			gain_out <= GAIN_0DB;
		end else if (!hold_in) begin
			// all-zero folded onto the nominal 0 dB code
			gain_out <= (code_in == GAIN_ALT_0DB) ? GAIN_0DB : code_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			mute_out <= 1'b0;
		end else if (!hold_in) begin
			mute_out <= (code_in == GAIN_MUTE);
		end
	end

endmodule

/* File: verilog/dcg_regs.sv */
// register bank for codec gains, routing and codec 2 configuration
module dcg_regs (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic codec1_soft_reset_in,
	input wire logic codec1_adc_overflow_in,
	input wire logic codec2_adc_overflow_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rd_valid_out,
	output logic [4:0] c1_input_sel_out,
	output logic [2:0] c1_output_sel_out,
	output logic c1_line_output_out,
	output logic [4:0] c2_input_sel_out,
	output logic c2_handset_output_out,
	output logic c2_line_output_out,
	output logic [3:0] c2_divider_out,
	output logic c2_analog_loopback_out,
	output logic c2_digital_loopback_out,
	output logic c2_power_down_out,
	output logic gain_hold_out,
	output dcg_pkg::dcg_gain_t c1_adc_gain_out,
	output dcg_pkg::dcg_gain_t c1_dac_gain_out,
	output dcg_pkg::dcg_gain_t c2_adc_gain_out,
	output dcg_pkg::dcg_gain_t c2_dac_gain_out,
	output logic [3:0] gain_mute_out
);
	import dcg_pkg::*;

	// ==========================================================
	// storage
	logic [6:0] c1_adc_ff;
	logic [5:0] c1_dac_ff;
	logic [7:0] c1_route_ff;
	logic [7:0] c2_div_ff;
	logic [7:1] c2_cfg_ff;
	logic [6:0] c2_adc_ff;
	logic [5:0] c2_dac_ff;
	logic [7:2] c2_route_ff;
	logic c1_ovf_ff;
	logic c2_ovf_ff;
	logic wr_c1_adc;
	logic wr_c1_dac;
	logic wr_c1_route;
	logic wr_c2_div;
	logic wr_c2_cfg;
	logic wr_c2_adc;
	logic wr_c2_dac;
	logic wr_c2_route;
	logic wr_ctrl;
	logic c1_grp_rst;
	logic c2_grp_rst;
	logic [7:0] nxt_rdata;
	dcg_gain_t gain_code [NUM_GAINS];
	dcg_gain_t gain_applied [NUM_GAINS];

	// ==========================================================
	// address decode
	assign wr_c1_adc = reg_wr_in && (reg_addr_in == ADDR_C1_ADC_GAIN);
	assign wr_c1_dac = reg_wr_in && (reg_addr_in == ADDR_C1_DAC_GAIN);
	assign wr_c1_route = reg_wr_in && (reg_addr_in == ADDR_C1_ROUTE);
	assign wr_c2_div = reg_wr_in && (reg_addr_in == ADDR_C2_DIVIDER);
	assign wr_c2_cfg = reg_wr_in && (reg_addr_in == ADDR_C2_CONFIG);
	assign wr_c2_adc = reg_wr_in && (reg_addr_in == ADDR_C2_ADC_GAIN);
	assign wr_c2_dac = reg_wr_in && (reg_addr_in == ADDR_C2_DAC_GAIN);
	assign wr_c2_route = reg_wr_in && (reg_addr_in == ADDR_C2_ROUTE);
	assign wr_ctrl = reg_wr_in && (reg_addr_in == ADDR_GAIN_CTRL);

	// soft reset wins over the data of the same write
	assign c1_grp_rst = sys_rst_in || codec1_soft_reset_in;
	assign c2_grp_rst = sys_rst_in || (wr_c2_cfg && reg_wdata_in[CFG_SRST_BIT]);

	// ==========================================================
	// codec 1 group
	always_ff @(posedge clk_in) begin
		if (c1_grp_rst) begin
			c1_adc_ff <= RST_C1_ADC;
		end else if (wr_c1_adc) begin
			c1_adc_ff <= reg_wdata_in[6:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (c1_grp_rst) begin
			c1_dac_ff <= RST_C1_DAC;
		end else if (wr_c1_dac) begin
			// upper two bits are not kept
			c1_dac_ff <= reg_wdata_in[5:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (c1_grp_rst) begin
			c1_route_ff <= RST_C1_ROUTE;
		end else if (wr_c1_route) begin
			c1_route_ff <= reg_wdata_in;
		end
	end

	// ==========================================================
	// codec 2 group
	always_ff @(posedge clk_in) begin
		if (c2_grp_rst) begin
			c2_div_ff <= RST_C2_DIVIDER;
		end else if (wr_c2_div) begin
			// kept as written; host is expected never to touch it
			c2_div_ff <= reg_wdata_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (c2_grp_rst) begin
			c2_cfg_ff <= RST_C2_CONFIG[7:1];
		end else if (wr_c2_cfg) begin
			c2_cfg_ff <= reg_wdata_in[7:1];
		end
	end

	always_ff @(posedge clk_in) begin
		if (c2_grp_rst) begin
			c2_adc_ff <= RST_C2_ADC;
		end else if (wr_c2_adc) begin
			c2_adc_ff <= reg_wdata_in[6:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (c2_grp_rst) begin
			c2_dac_ff <= RST_C2_DAC;
		end else if (wr_c2_dac) begin
			c2_dac_ff <= reg_wdata_in[5:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (c2_grp_rst) begin
			c2_route_ff <= RST_C2_ROUTE;
		end else if (wr_c2_route) begin
			// output routing bits 1..0 are not stored and read back as zero
			c2_route_ff <= reg_wdata_in[7:2];
		end
	end

	// ==========================================================
	// gain hold control, outside both soft reset groups
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			gain_hold_out <= RST_GAIN_CTRL[HOLD_BIT];
		end else if (wr_ctrl) begin
			gain_hold_out <= reg_wdata_in[HOLD_BIT];
		end
	end

	// ==========================================================
	// overflow flags: sticky until read, a new overflow beats the clear
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			c1_ovf_ff <= 1'b0;
		end else if (codec1_adc_overflow_in) begin
			c1_ovf_ff <= 1'b1;
		end else if (reg_rd_in && reg_addr_in == ADDR_C1_ADC_GAIN) begin
			c1_ovf_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			c2_ovf_ff <= 1'b0;
		end else if (codec2_adc_overflow_in) begin
			c2_ovf_ff <= 1'b1;
		end else if (reg_rd_in && reg_addr_in == ADDR_C2_ADC_GAIN) begin
			c2_ovf_ff <= 1'b0;
		end
	end

	// ==========================================================
	// read path, one cycle latency, unmapped reads as zero
	always_comb begin
		nxt_rdata = 8'h00;
		unique case (reg_addr_in)
			ADDR_C1_ADC_GAIN: nxt_rdata = {c1_ovf_ff, c1_adc_ff};
			ADDR_C1_DAC_GAIN: nxt_rdata = {2'b00, c1_dac_ff};
			ADDR_C1_ROUTE: nxt_rdata = c1_route_ff;
			ADDR_C2_DIVIDER: nxt_rdata = c2_div_ff;
			// reset request bit always reads back zero
			ADDR_C2_CONFIG: nxt_rdata = {c2_cfg_ff, 1'b0};
			ADDR_C2_ADC_GAIN: nxt_rdata = {c2_ovf_ff, c2_adc_ff};
			ADDR_C2_DAC_GAIN: nxt_rdata = {2'b00, c2_dac_ff};
			ADDR_C2_ROUTE: nxt_rdata = {c2_route_ff, 2'b00};
			ADDR_GAIN_CTRL: nxt_rdata = {VERSION_ID, 1'b1, gain_hold_out, 2'b00};
			default: nxt_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			reg_rdata_out <= nxt_rdata;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			reg_rd_valid_out <= 1'b0;
		end else begin
			reg_rd_valid_out <= reg_rd_in;
		end
	end

	// ==========================================================
	// control outputs straight from the stored fields
	assign c1_input_sel_out = c1_route_ff[7:ROUTE_IN_LSB];
	assign c1_output_sel_out = c1_route_ff[2:ROUTE_OUT_LSB];
	assign c1_line_output_out = c1_adc_ff[LINE_OUT_BIT];
	assign c2_input_sel_out = c2_route_ff[7:ROUTE_IN_LSB];
	assign c2_handset_output_out = c2_route_ff[2];
	assign c2_line_output_out = c2_adc_ff[LINE_OUT_BIT];
	assign c2_divider_out = c2_cfg_ff[7:CFG_DIV_LSB];
	assign c2_analog_loopback_out = c2_cfg_ff[CFG_ALOOP_BIT];
	assign c2_digital_loopback_out = c2_cfg_ff[CFG_DLOOP_BIT];
	assign c2_power_down_out = c2_cfg_ff[CFG_PDN_BIT];

	// ==========================================================
	// applied gains
	assign gain_code[0] = c1_adc_ff[6:ADC_GAIN_LSB];
	assign gain_code[1] = c1_dac_ff;
	assign gain_code[2] = c2_adc_ff[6:ADC_GAIN_LSB];
	assign gain_code[3] = c2_dac_ff;

	generate
		for (genvar g = 0; g < NUM_GAINS; g++) begin : g_gain
			dcg_gain_apply u_apply (
				.clk_in(clk_in),
				.sys_rst_in(sys_rst_in),
				.hold_in(gain_hold_out),
				.code_in(gain_code[g]),
				.gain_out(gain_applied[g]),
				.mute_out(gain_mute_out[g])
			);
		end
	endgenerate

	assign c1_adc_gain_out = gain_applied[0];
	assign c1_dac_gain_out = gain_applied[1];
	assign c2_adc_gain_out = gain_applied[2];
	assign c2_dac_gain_out = gain_applied[3];

endmodule

/* File: verification/dcg_regs_properties.sv */
// concurrent checks on the register bank ports
module dcg_regs_properties import dcg_pkg::*; (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic codec1_soft_reset_in,
	input wire logic reg_rd_valid_out,
	input wire logic [4:0] c1_input_sel_out,
	input wire logic [2:0] c1_output_sel_out,
	input wire logic c2_line_output_out,
	input wire logic [3:0] c2_divider_out,
	input wire logic c2_analog_loopback_out,
	input wire logic c2_digital_loopback_out,
	input wire logic c2_power_down_out,
	input wire logic gain_hold_out,
	input wire dcg_pkg::dcg_gain_t c1_dac_gain_out,
	input wire logic [3:0] gain_mute_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// properties
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	dcg_gain_t wcode;
	assign wcode = reg_wdata_in[5:0];
	// soft reset of codec 1 would mask the write, so it is excluded
	sequence s_dac_wr;
		reg_wr_in && reg_addr_in == ADDR_C1_DAC_GAIN && !codec1_soft_reset_in
		##1 !gain_hold_out && !codec1_soft_reset_in;
	endsequence
	sequence s_cfg_wr;
		reg_wr_in && reg_addr_in == ADDR_C2_CONFIG;
	endsequence
	AST_RD_PULSE: assert property (reg_rd_in |=> reg_rd_valid_out)
		else $error("read valid missing");
	AST_RD_QUIET: assert property (!reg_rd_in |=> !reg_rd_valid_out)
		else $error("read valid without read");
	AST_ROUTE: assert property (reg_wr_in && reg_addr_in == ADDR_C1_ROUTE && !codec1_soft_reset_in
		|=> {c1_input_sel_out, c1_output_sel_out} == $past(reg_wdata_in)) else $error("route");
	AST_CFG: assert property (s_cfg_wr and !reg_wdata_in[0] |=> {c2_divider_out,
		c2_analog_loopback_out, c2_digital_loopback_out, c2_power_down_out} == $past(reg_wdata_in[7:1]))
		else $error("config");
	AST_SRST: assert property (s_cfg_wr and reg_wdata_in[0] |=> c2_divider_out == 4'h5
		&& !c2_power_down_out && !c2_analog_loopback_out) else $error("soft reset");
	AST_LINE: assert property (reg_wr_in && reg_addr_in == ADDR_C2_ADC_GAIN
		|=> c2_line_output_out == $past(reg_wdata_in[0])) else $error("line select");
	AST_GAIN: assert property (s_dac_wr |=> c1_dac_gain_out ==
		(($past(wcode, 2) == 6'h00) ? GAIN_0DB : $past(wcode, 2))) else $error("dac gain");
	AST_MUTE: assert property (s_dac_wr |=> gain_mute_out[1] == ($past(wcode, 2) == GAIN_MUTE))
		else $error("mute");
	AST_HOLD: assert property (gain_hold_out |=> $stable(c1_dac_gain_out))
		else $error("gain moved while held");
endmodule

/* File: verification/dcg_host.sv */
// host model driving the register strobe bus
module dcg_host (
	input wire logic clk_in,
	input wire logic [7:0] reg_rdata_out,
	output logic reg_wr_in,
	output logic reg_rd_in,
	output logic [7:0] reg_addr_in,
	output logic [7:0] reg_wdata_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// bus cycles, one whole byte each, address is the register number
	initial begin
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == 8'h06) return; // divider register is left at its default
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
		reg_wdata_in <= ~d;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		d = reg_rdata_out;
	endtask
endmodule

/* File: verification/dcg_regs_tb.sv */
// self-checking testbench for the register bank
module dcg_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dcg_pkg::*;
	// ==========================================
	// signals and instances
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic codec1_soft_reset_in = 1'b0;
	logic codec1_adc_overflow_in = 1'b0;
	logic codec2_adc_overflow_in = 1'b0;
	logic reg_wr_in, reg_rd_in, reg_rd_valid_out, c1_line_output_out, c2_handset_output_out;
	logic c2_line_output_out, c2_analog_loopback_out, c2_digital_loopback_out;
	logic c2_power_down_out, gain_hold_out;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, v;
	logic [4:0] c1_input_sel_out, c2_input_sel_out;
	logic [2:0] c1_output_sel_out;
	logic [3:0] c2_divider_out, gain_mute_out;
	dcg_gain_t c1_adc_gain_out, c1_dac_gain_out, c2_adc_gain_out, c2_dac_gain_out;
	int n_mismatch = 0;
	int total_checks = 0;
	always #5 clk_in = ~clk_in;
	dcg_regs u_dut (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.codec1_soft_reset_in(codec1_soft_reset_in),
		.codec1_adc_overflow_in(codec1_adc_overflow_in),
		.codec2_adc_overflow_in(codec2_adc_overflow_in),
		.reg_rdata_out(reg_rdata_out),
		.reg_rd_valid_out(reg_rd_valid_out),
		.c1_input_sel_out(c1_input_sel_out),
		.c1_output_sel_out(c1_output_sel_out),
		.c1_line_output_out(c1_line_output_out),
		.c2_input_sel_out(c2_input_sel_out),
		.c2_handset_output_out(c2_handset_output_out),
		.c2_line_output_out(c2_line_output_out),
		.c2_divider_out(c2_divider_out),
		.c2_analog_loopback_out(c2_analog_loopback_out),
		.c2_digital_loopback_out(c2_digital_loopback_out),
		.c2_power_down_out(c2_power_down_out),
		.gain_hold_out(gain_hold_out),
		.c1_adc_gain_out(c1_adc_gain_out),
		.c1_dac_gain_out(c1_dac_gain_out),
		.c2_adc_gain_out(c2_adc_gain_out),
		.c2_dac_gain_out(c2_dac_gain_out),
		.gain_mute_out(gain_mute_out)
	);
	dcg_host u_host (
		.clk_in(clk_in),
		.reg_rdata_out(reg_rdata_out),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in)
	);
	// ==========================================
	// helpers
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, v);
		chk("read data", e, v);
	endtask
	task automatic tick;
		@(posedge clk_in);
		#1;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset;
		rdchk(ADDR_C1_ADC_GAIN, 8'h00);
		rdchk(ADDR_C1_DAC_GAIN, 8'h00);
		rdchk(ADDR_C1_ROUTE, 8'h84);
		rdchk(ADDR_C2_CONFIG, 8'h50);
		rdchk(ADDR_C2_ADC_GAIN, 8'h01);
		rdchk(8'h20, 8'h00);
		rdchk(ADDR_GAIN_CTRL, RST_GAIN_CTRL);
		chk("dac gain", {2'b00, GAIN_0DB}, {2'b00, c1_dac_gain_out});
		chk("c1 adc gain", {2'b00, GAIN_0DB}, {2'b00, c1_adc_gain_out});
		$display("test reset done");
	endtask
	task automatic t_route;
		u_host.wr(ADDR_C1_ROUTE, 8'h5B);
		chk("c1 route", 8'h5B, {c1_input_sel_out, c1_output_sel_out});
		u_host.wr(ADDR_C2_ROUTE, 8'hFF);
		rdchk(ADDR_C2_ROUTE, 8'hFC);
		chk("c2 route", 8'hFC, {c2_input_sel_out, c2_handset_output_out, 2'b00});
		$display("test route done");
	endtask
	task automatic t_cfg;
		u_host.wr(ADDR_C2_CONFIG, 8'h3E);
		chk("config", 8'h3E, {c2_divider_out, c2_analog_loopback_out, c2_digital_loopback_out, c2_power_down_out, 1'b0});
		u_host.wr(ADDR_C2_ADC_GAIN, 8'h7E);
		tick();
		chk("c2 adc", 8'h3F, {2'b00, c2_adc_gain_out});
		chk("c2 line", 8'h00, {7'h00, c2_line_output_out});
		u_host.wr(ADDR_C1_ADC_GAIN, 8'h03);
		chk("c1 line", 8'h01, {7'h00, c1_line_output_out});
		tick();
		chk("c1 adc", 8'h01, {2'b00, c1_adc_gain_out});
		u_host.wr(ADDR_C2_CONFIG, 8'hFF);
		rdchk(ADDR_C2_CONFIG, 8'h50);
		rdchk(ADDR_C2_ADC_GAIN, 8'h01);
		rdchk(ADDR_C2_ROUTE, 8'h10);
		rdchk(ADDR_C1_ROUTE, 8'h5B);
		$display("test config done");
	endtask
	task automatic t_gain;
		u_host.wr(ADDR_C1_DAC_GAIN, 8'hF0);
		tick();
		chk("mute", 8'h02, {4'h0, gain_mute_out});
		rdchk(ADDR_C1_DAC_GAIN, 8'h30);
		u_host.wr(ADDR_GAIN_CTRL, 8'h04);
		rdchk(ADDR_GAIN_CTRL, {VERSION_ID, 1'b1, 1'b1, 2'b00});
		chk("hold", 8'h01, {7'h00, gain_hold_out});
		u_host.wr(ADDR_C1_DAC_GAIN, 8'h00);
		repeat (3) tick();
		chk("held", 8'h30, {2'b00, c1_dac_gain_out});
		u_host.wr(ADDR_GAIN_CTRL, 8'h00);
		repeat (2) tick();
		chk("released", {2'b00, GAIN_0DB}, {2'b00, c1_dac_gain_out});
		u_host.wr(ADDR_C2_DAC_GAIN, 8'hC1);
		tick();
		chk("c2 dac", 8'h01, {2'b00, c2_dac_gain_out});
		$display("test gain done");
	endtask
	task automatic t_flags;
		@(posedge clk_in);
		codec2_adc_overflow_in <= 1'b1;
		codec1_adc_overflow_in <= 1'b1;
		@(posedge clk_in);
		codec2_adc_overflow_in <= 1'b0;
		codec1_adc_overflow_in <= 1'b0;
		rdchk(ADDR_C2_ADC_GAIN, 8'h81);
		rdchk(ADDR_C2_ADC_GAIN, 8'h01);
		rdchk(ADDR_C1_ADC_GAIN, 8'h83);
		@(posedge clk_in);
		codec1_soft_reset_in <= 1'b1;
		@(posedge clk_in);
		codec1_soft_reset_in <= 1'b0;
		rdchk(ADDR_C1_ROUTE, 8'h84);
		rdchk(ADDR_C1_ADC_GAIN, 8'h00);
		rdchk(ADDR_C2_ROUTE, 8'h10);
		rdchk(ADDR_C2_DAC_GAIN, 8'h01);
		$display("test flags done");
	endtask
	initial begin
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		t_reset();
		t_route();
		t_cfg();
		t_gain();
		t_flags();
		tally_and_finish();
	end
	// tests need under a hundred cycles, so 20000 is a generous ceiling
	initial begin
		#200000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule
bind dcg_regs dcg_regs_properties u_chk (
	.clk_in(clk_in),
	.sys_rst_in(sys_rst_in),
	.reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in),
	.reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in),
	.codec1_soft_reset_in(codec1_soft_reset_in),
	.reg_rd_valid_out(reg_rd_valid_out),
	.c1_input_sel_out(c1_input_sel_out),
	.c1_output_sel_out(c1_output_sel_out),
	.c2_line_output_out(c2_line_output_out),
	.c2_divider_out(c2_divider_out),
	.c2_analog_loopback_out(c2_analog_loopback_out),
	.c2_digital_loopback_out(c2_digital_loopback_out),
	.c2_power_down_out(c2_power_down_out),
	.gain_hold_out(gain_hold_out),
	.c1_dac_gain_out(c1_dac_gain_out),
	.gain_mute_out(gain_mute_out)
);
